// >>> core/adcsc_ctrl.sv
// sequencing control of a 10-bit successive-approximation converter
// Function
// - clearing converter_on stops operation and discards the result buffer.
// - halt_in_idle set freezes the converter while the device idles.
// - result_layout gives unsigned or signed integer, or left-justified fractions.
// - trigger 000 converts when software clears acquire_phase.
// - trigger 111 converts after acquire_time_count conversion clocks.
// - codes 110, 100, 010, 001 convert on external events; 101, 011 unused.
// - auto_acquire_start restarts acquisition after each conversion.
// - without auto start, acquisition begins only when software sets acquire_phase.
// - acquire_phase reads 1 while acquiring, 0 while holding.
// - done reads 1 after a conversion; software may clear it.
// - reference_select picks supply or external references; 1xx acts as 000.
// - scan_enable steps setting A through the scan channels.
// - interrupt flag rises after sequences_per_irq plus one sequences.
// - buffer_split_mode makes two alternating 8-word halves, else one 16-word.
// - active_half_flag 1 means entries 08-0F are being filled.
// - mux_toggle_mode uses A first, then alternates B and A.
// - thirteen analog pin channels, sixteen-word result buffer.
// - acquire_time_count gives 0 to 31 conversion clock periods.
// - conversion clock period is clock period times divider plus one, with the divider capped at 63.
// - input select codes 00000 to 01100 are pins, higher are internal.
// - scanning steps through the channels set in scan_channel_mask; an empty mask selects channel 15.
`timescale 1ns/1ps
module adcsc_ctrl (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [adcsc_pkg::AW-1:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rd_data_o,
    input wire logic idle_i,
    input wire adcsc_pkg::adcsc_trg_s trg_i,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output adcsc_pkg::adcsc_ana_s ana_o,
    output logic converter_irq_flag_o
);
    adcsc_pkg::adcsc_q_s q;
    adcsc_pkg::adcsc_q_s d;
    logic [15:0] fmt;
    logic run;
    logic tad_tick;
    logic fire;
    logic wrap;
    logic [7:0] div;
    logic [3:0] waddr;
    logic [4:0] chan;

    // next channel set in the mask after cur, wrapping; keeps cur if none
    function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [15:0] mask);
        logic [3:0] idx;
        logic [3:0] res;
        logic hit;
        res = cur;
        hit = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            idx = 4'(cur + 4'(i));
            if (!hit && mask[idx]) begin
                res = idx;
                hit = 1'b1;
            end
        end
        return res;
    endfunction

    // layout of the incoming result
    adcsc_format u_format (
        .raw_i(conv_data_i),
        .result_layout_i(q.cfg.result_layout),
        .word_o(fmt)
    );

    // conversion clock, acquisition trigger and buffer address
    always_comb begin
        run = q.cfg.on && !(q.cfg.halt && idle_i);
        div = (q.cfg.conv_clock_divider > adcsc_pkg::CONV_CLOCK_DIVIDER_MAX) ? adcsc_pkg::CONV_CLOCK_DIVIDER_MAX : q.cfg.conv_clock_divider;
        tad_tick = (q.tad_cnt >= div);
        unique case (q.cfg.src)
            adcsc_pkg::TRG_SW: fire = !q.acquire_phase;
            adcsc_pkg::TRG_EXT0: fire = trg_i.ext0 && !q.ext0_q;
            adcsc_pkg::TRG_T3: fire = trg_i.t3;
            adcsc_pkg::TRG_T5: fire = trg_i.t5;
            adcsc_pkg::TRG_CTU: fire = trg_i.ctu;
            adcsc_pkg::TRG_AUTO: fire = (q.acq_cnt >= q.cfg.acquire_time_count);
            default: fire = 1'b0; // reserved codes never end acquisition
        endcase
        wrap = (q.seq == q.cfg.sequences_per_irq);
        // split mode keeps the pointer inside the half being filled
        waddr = q.cfg.split ? {q.half, q.ptr[2:0]} : q.ptr;
        if (q.use_b) begin
            chan = q.cfg.sel_b;
        end else if (q.cfg.scan) begin
            chan = {1'b0, q.scan_idx};
        end else begin
            chan = q.cfg.sel_a;
        end
    end

    // whole next-state update
    always_comb begin
        d = q;
        d.ext0_q = trg_i.ext0;
        d.rdata = adcsc_pkg::RST_REG;
        d.ana.start = 1'b0;

        // software writes; hardware updates below take priority
        if (wr_i) begin
            if (addr_i == adcsc_pkg::OFF_CON1) begin
                d.cfg.on = wr_data_i[adcsc_pkg::C1_ON];
                d.cfg.halt = wr_data_i[adcsc_pkg::C1_HALT];
                d.cfg.result_layout = wr_data_i[adcsc_pkg::C1_RESULT_LAYOUT +: 2];
                d.cfg.src = wr_data_i[adcsc_pkg::C1_SRC +: 3];
                d.cfg.auto_acquire_start = wr_data_i[adcsc_pkg::C1_AUTO_ACQUIRE_START];
                d.acquire_phase = wr_data_i[adcsc_pkg::C1_ACQUIRE_PHASE];
                if (!wr_data_i[adcsc_pkg::C1_DONE]) begin
                    d.done = 1'b0;
                end
            end else if (addr_i == adcsc_pkg::OFF_CON2) begin
                d.cfg.vref = wr_data_i[adcsc_pkg::C2_VREF +: 3];
                d.cfg.scan = wr_data_i[adcsc_pkg::C2_SCAN];
                d.cfg.sequences_per_irq = wr_data_i[adcsc_pkg::C2_SEQUENCES_PER_IRQ +: 4];
                d.cfg.split = wr_data_i[adcsc_pkg::C2_SPLIT];
                d.cfg.alt = wr_data_i[adcsc_pkg::C2_ALT];
            end else if (addr_i == adcsc_pkg::OFF_CON3) begin
                d.cfg.acquire_time_count = wr_data_i[adcsc_pkg::C3_ACQUIRE_TIME_COUNT +: 5];
                d.cfg.conv_clock_divider = wr_data_i[adcsc_pkg::C3_CONV_CLOCK_DIVIDER +: 8];
            end else if (addr_i == adcsc_pkg::OFF_CHS) begin
                d.cfg.sel_b = wr_data_i[adcsc_pkg::CH_SB +: 5];
                d.cfg.sel_a = wr_data_i[adcsc_pkg::CH_SA +: 5];
            end else if (addr_i == adcsc_pkg::OFF_SCAN) begin
                d.cfg.mask = wr_data_i;
            end else if (addr_i == adcsc_pkg::OFF_STAT) begin
                if (!wr_data_i[adcsc_pkg::ST_IRQ]) begin
                    d.irq = 1'b0;
                end
            end
        end

        // register reads, answer in the next cycle only
        if (rd_i) begin
            if (addr_i[5:4] == adcsc_pkg::BUF_PAGE) begin
                d.rdata = q.rbuf[addr_i[3:0]];
            end else begin
                case (addr_i)
                    adcsc_pkg::OFF_CON1: begin
                        d.rdata[adcsc_pkg::C1_ON] = q.cfg.on;
                        d.rdata[adcsc_pkg::C1_HALT] = q.cfg.halt;
                        d.rdata[adcsc_pkg::C1_RESULT_LAYOUT +: 2] = q.cfg.result_layout;
                        d.rdata[adcsc_pkg::C1_SRC +: 3] = q.cfg.src;
                        d.rdata[adcsc_pkg::C1_AUTO_ACQUIRE_START] = q.cfg.auto_acquire_start;
                        d.rdata[adcsc_pkg::C1_ACQUIRE_PHASE] = q.acquire_phase;
                        d.rdata[adcsc_pkg::C1_DONE] = q.done;
                    end
                    adcsc_pkg::OFF_CON2: begin
                        d.rdata[adcsc_pkg::C2_VREF +: 3] = q.cfg.vref;
                        d.rdata[adcsc_pkg::C2_SCAN] = q.cfg.scan;
                        d.rdata[adcsc_pkg::C2_HALF] = q.half;
                        d.rdata[adcsc_pkg::C2_SEQUENCES_PER_IRQ +: 4] = q.cfg.sequences_per_irq;
                        d.rdata[adcsc_pkg::C2_SPLIT] = q.cfg.split;
                        d.rdata[adcsc_pkg::C2_ALT] = q.cfg.alt;
                    end
                    adcsc_pkg::OFF_CON3: begin
                        d.rdata[adcsc_pkg::C3_ACQUIRE_TIME_COUNT +: 5] = q.cfg.acquire_time_count;
                        d.rdata[adcsc_pkg::C3_CONV_CLOCK_DIVIDER +: 8] = q.cfg.conv_clock_divider;
                    end
                    adcsc_pkg::OFF_CHS: begin
                        d.rdata[adcsc_pkg::CH_SB +: 5] = q.cfg.sel_b;
                        d.rdata[adcsc_pkg::CH_SA +: 5] = q.cfg.sel_a;
                    end
                    adcsc_pkg::OFF_SCAN: d.rdata = q.cfg.mask;
                    adcsc_pkg::OFF_STAT: d.rdata[adcsc_pkg::ST_IRQ] = q.irq;
                    default: d.rdata = adcsc_pkg::RST_REG; // unmapped reads zero
                endcase
            end
        end

        // sequencing; everything holds while halted in idle
        if (!q.cfg.on) begin
            d.st = adcsc_pkg::ST_HOLD;
            d.rbuf = '0;
            d.ptr = 4'h0;
            d.seq = 4'h0;
            d.half = 1'b0;
            d.use_b = 1'b0;
            d.tad_cnt = 8'h00;
            d.acq_cnt = 5'h00;
            d.scan_idx = next_scan(4'hf, q.cfg.mask);
        end else if (run) begin
            d.tad_cnt = tad_tick ? 8'h00 : 8'(q.tad_cnt + 8'h01);
            unique case (q.st)
                adcsc_pkg::ST_HOLD: begin
                    d.acq_cnt = 5'h00;
                    if (q.acquire_phase) begin
                        d.st = adcsc_pkg::ST_ACQ;
                    end
                end
                adcsc_pkg::ST_ACQ: begin
                    if (tad_tick && q.acq_cnt != 5'h1f) begin
                        d.acq_cnt = 5'(q.acq_cnt + 5'h01);
                    end
                    if (fire) begin
                        d.acquire_phase = 1'b0;
                        d.st = adcsc_pkg::ST_CONV;
                        d.ana.start = 1'b1;
                    end
                end
                adcsc_pkg::ST_CONV: begin
                    d.acq_cnt = 5'h00;
                    if (conv_done_i) begin
                        d.rbuf[waddr] = fmt;
                        d.done = 1'b1;
                        // auto start wins over a software clear in this cycle
                        if (q.cfg.auto_acquire_start) begin
                            d.acquire_phase = 1'b1;
                            d.st = adcsc_pkg::ST_ACQ;
                        end else begin
                            d.st = adcsc_pkg::ST_HOLD;
                        end
                        d.use_b = q.cfg.alt && !q.use_b;
                        if (!q.use_b && q.cfg.scan) begin
                            d.scan_idx = next_scan(q.scan_idx, q.cfg.mask);
                        end
                        if (wrap) begin
                            d.irq = 1'b1;
                            d.seq = 4'h0;
                            d.ptr = 4'h0;
                            d.half = q.cfg.split && !q.half;
                            d.use_b = 1'b0;
                            d.scan_idx = next_scan(4'hf, q.cfg.mask);
                        end else begin
                            d.seq = 4'(q.seq + 4'h1);
                            d.ptr = 4'(q.ptr + 4'h1);
                        end
                    end
                end
                default: d.st = adcsc_pkg::ST_HOLD; // illegal code recovers
            endcase
        end

        // analog side controls, registered
        d.ana.sample = (d.st == adcsc_pkg::ST_ACQ);
        d.ana.vref_pos_ext = !q.cfg.vref[2] && q.cfg.vref[0];
        d.ana.vref_neg_ext = !q.cfg.vref[2] && q.cfg.vref[1];
        d.ana.chan = chan;
        d.ana.internal = (chan > adcsc_pkg::LAST_PIN_CH);
    end

    // single state register; every control field clears at reset
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign rd_data_o = q.rdata;
    assign ana_o = q.ana;
    assign converter_irq_flag_o = q.irq;
endmodule

// >>> core/adcsc_format.sv
// result layout of a 10-bit conversion into a 16-bit buffer word
`timescale 1ns/1ps
module adcsc_format (
    input wire logic [9:0] raw_i,
    input wire logic [1:0] result_layout_i,
    output logic [15:0] word_o
);
    logic [9:0] sgn;

    // signed codes are offset binary: flip the top bit for two's complement
    always_comb begin
        sgn = {~raw_i[9], raw_i[8:0]};
        unique case (result_layout_i)
            adcsc_pkg::FMT_UINT: word_o = {6'h00, raw_i};
            adcsc_pkg::FMT_SINT: word_o = {{6{sgn[9]}}, sgn};
            adcsc_pkg::FMT_UFRAC: word_o = {raw_i, 6'h00};
            adcsc_pkg::FMT_SFRAC: word_o = {sgn, 6'h00};
        endcase
    end
endmodule

// >>> core/adcsc_pkg.sv
// constants and shared types of the converter sequencing control
package adcsc_pkg;
    // register addresses on the plain register port
    localparam int AW = 6;
    localparam logic [5:0] OFF_CON1 = 6'h00;
    localparam logic [5:0] OFF_CON2 = 6'h01;
    localparam logic [5:0] OFF_CON3 = 6'h02;
    localparam logic [5:0] OFF_CHS = 6'h03;
    localparam logic [5:0] OFF_SCAN = 6'h04;
    localparam logic [5:0] OFF_STAT = 6'h05;
    localparam logic [1:0] BUF_PAGE = 2'h1;
    // converter_control_one fields
    localparam int C1_ON = 15;
    localparam int C1_HALT = 13;
    localparam int C1_RESULT_LAYOUT = 8;
    localparam int C1_SRC = 5;
    localparam int C1_AUTO_ACQUIRE_START = 2;
    localparam int C1_ACQUIRE_PHASE = 1;
    localparam int C1_DONE = 0;
    // converter_control_two fields
    localparam int C2_VREF = 13;
    localparam int C2_SCAN = 10;
    localparam int C2_HALF = 7;
    localparam int C2_SEQUENCES_PER_IRQ = 2;
    localparam int C2_SPLIT = 1;
    localparam int C2_ALT = 0;
    // timing, input select and status fields
    localparam int C3_ACQUIRE_TIME_COUNT = 8;
    localparam int C3_CONV_CLOCK_DIVIDER = 0;
    localparam int CH_SB = 8;
    localparam int CH_SA = 0;
    localparam int ST_IRQ = 0;
    // reset value of every control field
    localparam logic [15:0] RST_REG = 16'h0000;
    // trigger source codes
    localparam logic [2:0] TRG_SW = 3'h0;
    localparam logic [2:0] TRG_EXT0 = 3'h1;
    localparam logic [2:0] TRG_T3 = 3'h2;
    localparam logic [2:0] TRG_T5 = 3'h4;
    localparam logic [2:0] TRG_CTU = 3'h6;
    localparam logic [2:0] TRG_AUTO = 3'h7;
    // result layout codes
    localparam logic [1:0] FMT_UINT = 2'h0;
    localparam logic [1:0] FMT_SINT = 2'h1;
    localparam logic [1:0] FMT_UFRAC = 2'h2;
    localparam logic [1:0] FMT_SFRAC = 2'h3;
    // highest code that selects an analog pin, largest legal divider
    localparam logic [4:0] LAST_PIN_CH = 5'h0c;
    localparam logic [7:0] CONV_CLOCK_DIVIDER_MAX = 8'h3f;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b11
    } adcsc_state_e;

    typedef struct packed {
        logic on;
        logic halt;
        logic [1:0] result_layout;
        logic [2:0] src;
        logic auto_acquire_start;
        logic [2:0] vref;
        logic scan;
        logic [3:0] sequences_per_irq;
        logic split;
        logic alt;
        logic [4:0] acquire_time_count;
        logic [7:0] conv_clock_divider;
        logic [4:0] sel_b;
        logic [4:0] sel_a;
        logic [15:0] mask;
    } adcsc_cfg_s;

    // toward the analog sample-hold and converter core
    typedef struct packed {
        logic sample;
        logic start;
        logic vref_pos_ext;
        logic vref_neg_ext;
        logic [4:0] chan;
        logic internal;
    } adcsc_ana_s;

    // external trigger events, synchronous to the clock
    typedef struct packed {
        logic ctu;
        logic t3;
        logic t5;
        logic ext0;
    } adcsc_trg_s;

    typedef struct packed {
        adcsc_cfg_s cfg;
        adcsc_state_e st;
        logic acquire_phase;
        logic done;
        logic irq;
        logic half;
        logic [3:0] ptr;
        logic [3:0] seq;
        logic use_b;
        logic [3:0] scan_idx;
        logic [7:0] tad_cnt;
        logic [4:0] acq_cnt;
        logic ext0_q;
        logic [15:0] rdata;
        adcsc_ana_s ana;
        logic [15:0][15:0] rbuf;
    } adcsc_q_s;
endpackage

// >>> testbench/adcsc_core_model.sv
// behavioural sample-hold and converter core
`timescale 1ns/1ps
module adcsc_core_model (
    input wire logic ref_clk_i,
    input wire adcsc_pkg::adcsc_ana_s ana_i,
    input wire logic [9:0] data_i,
    input wire logic [3:0] lat_i,
    output logic conv_done_o,
    output logic [9:0] conv_data_o
);
    logic [9:0] mix = 10'h000;
    initial conv_done_o = 1'b0;
    initial conv_data_o = 10'h3ff;
    // answer each start after a chosen latency; data is junk outside the pulse
    always begin
        @(posedge ref_clk_i);
        if (ana_i.start) begin
            repeat (lat_i) @(posedge ref_clk_i);
            mix = mix + 10'h0a7;
            conv_done_o <= 1'b1;
            conv_data_o <= data_i ^ mix;
            @(posedge ref_clk_i);
            conv_done_o <= 1'b0;
            conv_data_o <= ~(data_i ^ mix);
        end
    end
endmodule

// >>> testbench/adcsc_properties.sv
// port checks of the converter sequencing control
`timescale 1ns/1ps
module adcsc_properties (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [adcsc_pkg::AW-1:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rd_data_o,
    input wire logic idle_i,
    input wire adcsc_pkg::adcsc_trg_s trg_i,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    input wire adcsc_pkg::adcsc_ana_s ana_o,
    input wire logic converter_irq_flag_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [2:0] vsel_q;
    // last reference code written, kept for the output check
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vsel_q <= 3'h0;
        end else if (wr_i && addr_i == adcsc_pkg::OFF_CON2) begin
            vsel_q <= wr_data_i[15:13];
        end
    end
    sequence s_off;
        wr_i && addr_i == adcsc_pkg::OFF_CON1 && !wr_data_i[adcsc_pkg::C1_ON];
    endsequence
    sequence s_clr;
        wr_i && addr_i == adcsc_pkg::OFF_STAT && !wr_data_i[0] && !conv_done_i
            && !$past(conv_done_i);
    endsequence
    property p_start_pulse;
        ana_o.start |=> (!ana_o.start) [*2];
    endproperty
    property p_start_hold;
        ana_o.start |-> !ana_o.sample && $past(ana_o.sample);
    endproperty
    property p_off_quiet;
        s_off |-> ##2 (!ana_o.sample && !ana_o.start) [*3];
    endproperty
    property p_irq_clear;
        s_clr ##1 !conv_done_i |=> !converter_irq_flag_o;
    endproperty
    property p_irq_cause;
        $rose(converter_irq_flag_o) |-> $past(conv_done_i) || $past(conv_done_i, 2);
    endproperty
    property p_internal;
        ana_o.internal == (ana_o.chan > adcsc_pkg::LAST_PIN_CH);
    endproperty
    property p_vref;
        wr_i && addr_i == adcsc_pkg::OFF_CON2 |-> ##2
            ana_o.vref_pos_ext == (!vsel_q[2] && vsel_q[0])
            && ana_o.vref_neg_ext == (!vsel_q[2] && vsel_q[1]);
    endproperty
    property p_rd_unmapped;
        rd_i && addr_i == 6'h08 |=> rd_data_o == 16'h0000;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    a_start_hold: assert property (p_start_hold) else $error("start without sampling");
    a_off_quiet: assert property (p_off_quiet) else $error("active while off");
    a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared");
    a_irq_cause: assert property (p_irq_cause) else $error("flag with no result");
    a_internal: assert property (p_internal) else $error("internal marker wrong");
    a_vref: assert property (p_vref) else $error("reference select wrong");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
endmodule

bind adcsc_ctrl adcsc_properties adcsc_properties_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .idle_i(idle_i), .trg_i(trg_i),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .ana_o(ana_o),
    .converter_irq_flag_o(converter_irq_flag_o)
);

// >>> testbench/test_adcsc_ctrl.sv
// self-checking bench of the converter sequencing control
`timescale 1ns/1ps
module test_adcsc_ctrl;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] addr_i = 6'h00;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic idle_i = 1'b0;
    logic [9:0] rnd = 10'h000;
    logic [3:0] lat = 4'h2;
    adcsc_pkg::adcsc_trg_s trg_i = '0;
    adcsc_pkg::adcsc_ana_s ana;
    logic [15:0] rd_data_o;
    logic [15:0] v;
    logic done;
    logic [9:0] data;
    logic irq;
    int error_cnt = 0;
    int checks_done = 0;
    logic [9:0] raw_q[$];
    logic [5:0] chan_q[$];
    logic [2:0] cs[5] = '{3'h5, 3'h6, 3'h4, 3'h2, 3'h1};
    logic [3:0] tm[5] = '{4'hf, 4'h8, 4'h2, 4'h4, 4'h1};

    adcsc_ctrl adcsc_ctrl_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .idle_i(idle_i), .trg_i(trg_i), .conv_done_i(done), .conv_data_i(data),
        .ana_o(ana), .converter_irq_flag_o(irq));
    adcsc_core_model adcsc_core_model_i (.ref_clk_i(ref_clk_i), .ana_i(ana),
        .data_i(rnd), .lat_i(lat), .conv_done_o(done), .conv_data_o(data));

    initial forever #50 ref_clk_i = ~ref_clk_i;
    // reference model: raw results and channels in order
    always @(posedge ref_clk_i) begin
        if (done) raw_q.push_back(data);
        if (ana.start) chan_q.push_back({ana.internal, ana.chan});
    end
    function automatic logic [15:0] fmt(input logic [9:0] r, input logic [1:0] f);
        logic [9:0] s;
        s = r ^ 10'h200;
        case (f)
            2'h0: fmt = {6'h00, r};
            2'h1: fmt = {{6{s[9]}}, s};
            2'h2: fmt = {r, 6'h00};
            default: fmt = {s, 6'h00};
        endcase
    endfunction
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, s, e);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rdc(input logic [5:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
        chk(v, e);
    endtask
    // bounded wait for a count of results, then let outputs settle
    task wq(input int n);
        for (int k = 0; k < 500 && raw_q.size() < n; k++) @(posedge ref_clk_i);
        chk(16'(raw_q.size() >= n), 16'h0001);
        repeat (3) @(posedge ref_clk_i);
        // look past the edge so registered outputs have settled
        #1;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        end_sim();
    end

    initial begin
        int n;
        void'($urandom(11));
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 6; a++) rdc(a[5:0], 16'h0000);
        rdc(6'h08, 16'h0000);
        // software trigger, every layout, result always lands in entry 0
        for (int f = 0; f < 4; f++) begin
            n = raw_q.size();
            rnd <= 10'($urandom);
            lat <= 4'($urandom & 7);
            wr(adcsc_pkg::OFF_CON1, {6'h20, f[1:0], 8'h02});
            repeat (4) @(posedge ref_clk_i);
            #1;
            chk({14'h0, ana.sample, ana.start}, 16'h0002);
            wr(adcsc_pkg::OFF_CON1, {6'h20, f[1:0], 8'h00});
            wq(n + 1);
            rdc(adcsc_pkg::OFF_CON1, {6'h20, f[1:0], 8'h01});
            rdc({adcsc_pkg::BUF_PAGE, 4'h0}, fmt(raw_q[n], f[1:0]));
            chk({15'h0, irq}, 16'h0001);
        end
        wr(adcsc_pkg::OFF_STAT, 16'h0000);
        wr(adcsc_pkg::OFF_CON1, 16'h8000);
        rdc(adcsc_pkg::OFF_CON1, 16'h8000);
        chk({15'h0, irq}, 16'h0000);
        // reserved code first, then each external event source
        for (int i = 0; i < 5; i++) begin
            n = raw_q.size();
            wr(adcsc_pkg::OFF_CON1, {8'h80, cs[i], 5'h02});
            repeat (3) @(posedge ref_clk_i);
            trg_i <= tm[i];
            @(posedge ref_clk_i);
            trg_i <= '0;
            // reserved code: no result is due, so wait a fixed span instead
            repeat (i == 0 ? 40 : 0) @(posedge ref_clk_i);
            wq(n + (i > 0));
            chk(16'(raw_q.size()), 16'(n + (i > 0)));
        end
        for (int i = 0; i < 8; i++) begin
            wr(adcsc_pkg::OFF_CON2, {i[2:0], 13'h0000});
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk({14'h0, ana.vref_pos_ext, ana.vref_neg_ext},
                {14'h0, i < 4 && i[0], i < 4 && i[1]});
        end
        // auto convert, auto start, split halves, toggled inputs, pacing of four
        wr(adcsc_pkg::OFF_CON3, 16'h0301);
        wr(adcsc_pkg::OFF_CHS, 16'h0d03);
        wr(adcsc_pkg::OFF_CON2, 16'h000f);
        chan_q.delete();
        n = raw_q.size();
        // external sources left the flag set; clear it before enabling
        wr(adcsc_pkg::OFF_STAT, 16'h0000);
        wr(adcsc_pkg::OFF_CON1, 16'h80e6);
        wq(n + 3);
        chk({15'h0, irq}, 16'h0000);
        wq(n + 4);
        chk({15'h0, irq}, 16'h0001);
        rdc(adcsc_pkg::OFF_CON2, 16'h008f);
        wr(adcsc_pkg::OFF_CON1, 16'h8000);
        for (int k = 0; k < 4; k++) begin
            rdc({adcsc_pkg::BUF_PAGE, k[3:0]}, fmt(raw_q[n + k], 2'h0));
            chk({10'h0, chan_q[k]}, k[0] ? 16'h002d : 16'h0003);
        end
        // halted while idle, resumes when idle ends
        repeat (50) @(posedge ref_clk_i);
        idle_i <= 1'b1;
        wr(adcsc_pkg::OFF_CON1, 16'ha0e6);
        n = raw_q.size();
        repeat (100) @(posedge ref_clk_i);
        chk(16'(raw_q.size()), 16'(n));
        idle_i <= 1'b0;
        wq(n + 1);
        chk(16'(raw_q.size() > n), 16'h0001);
        // switching off discards the buffer
        wr(adcsc_pkg::OFF_CON1, 16'h0000);
        repeat (3) @(posedge ref_clk_i);
        rdc({adcsc_pkg::BUF_PAGE, 4'h0}, 16'h0000);
        chk({15'h0, ana.sample}, 16'h0000);
        // scan channels 1 and 4, pacing of two: visits 1, 4, then restarts
        wr(adcsc_pkg::OFF_SCAN, 16'h0012);
        wr(adcsc_pkg::OFF_CON2, 16'h0404);
        chan_q.delete();
        n = raw_q.size();
        wr(adcsc_pkg::OFF_CON1, 16'h80e6);
        wq(n + 4);
        for (int k = 0; k < 4; k++) begin
            chk({10'h0, chan_q[k]}, k[0] ? 16'h0004 : 16'h0001);
        end
        end_sim();
    end
endmodule
